//--- include/dcp_pkg.sv
// Package for the converter control and serial pin block.
// Assumes a single 40 MHz core clock; all pins arrive unsynchronised.
package dcp_pkg;

	// ------------------------------------------------------------
	// Clock rates and timing
	// ------------------------------------------------------------
	localparam int unsigned MCLK_HZ       = 40_000_000;
	localparam int unsigned OSC_HZ        = 2_500_000;
	localparam int unsigned OSC_HALF_CYC  = MCLK_HZ / (2 * OSC_HZ);
	localparam int unsigned CONV_CLK_CYC  = 12;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int unsigned SR_W      = 8;
	localparam int unsigned BITCNT_W  = 3;
	localparam int unsigned RES_W     = 12;
	localparam int unsigned GPIO_N    = 4;
	localparam int unsigned OSCCNT_W  = 4;
	localparam int unsigned CONVCNT_W = 4;

	// ------------------------------------------------------------
	// Pin encodings
	// ------------------------------------------------------------
	localparam logic EDGE_FALL = 1'b0;
	localparam logic EDGE_RISE = 1'b1;

	typedef enum logic [0:0] {
		CONV_IDLE,
		CONV_RUN
	} dcp_conv_e;

	typedef struct packed {
		logic                 sclk_m;
		logic                 sclk_s;
		logic                 sclk_p;
		logic                 cs_m;
		logic                 cs_s;
		logic                 cs_p;
		logic                 esel_m;
		logic                 esel_s;
		logic                 din_m;
		logic                 din_s;
		logic                 conv_m;
		logic                 conv_s;
		logic                 conv_p;
		logic                 osel_m;
		logic                 osel_s;
		logic                 conversion_clock_m;
		logic                 conversion_clock_s;
		logic                 conversion_clock_p;
		logic [GPIO_N-1:0]    gin_m;
		logic [GPIO_N-1:0]    gin_s;
		logic [BITCNT_W-1:0]  bit_cnt;
		logic [SR_W-1:0]      rx_sr;
		logic [SR_W-1:0]      tx_sr;
		logic [SR_W-1:0]      rx_data;
		logic                 rx_valid;
		logic                 tx_req;
		logic                 sdo;
		logic                 din_oe_n;
		dcp_conv_e            st;
		logic [CONVCNT_W-1:0] conv_cnt;
		logic [OSCCNT_W-1:0]  osc_cnt;
		logic                 osc_clk;
		logic                 osc_oe_n;
		logic                 busy;
		logic [RES_W-1:0]     result;
		logic                 res_valid;
		logic                 conv_start;
		logic [GPIO_N-1:0]    gout;
		logic [GPIO_N-1:0]    goe_n;
	} dcp_state_s;

	// Master reset value: every field zero
	localparam dcp_state_s RST_STATE = '0;

endpackage

//--- rtl/dcp_top.sv
// Pin-level control of a 12-bit converter and its serial host port.
// Assumes pins are raw asynchronous levels; two-way pins are resolved
// outside from the output enables (low enable means driven).
`timescale 1ns/1ps

// Overview of operation
// - Master reset zeroes every internal register.
// - Edge select 0 falling, 1 rising.
// - Serial clock times both shift directions.
// - Convert rising edge starts a conversion.
// - Busy high while converting.
// - Select pin chooses oscillator output or input.
// - Three-wire: data-in pin only receives.
// - Two-wire: output data also on data-in.
// - Data out driven only while select low.
// - Data out same in both wire modes.
// - Serial port responds only with select low.
// - Select high: disabled, float, data-in input.
// - Conversions ignore chip select level.
// - Each general line is input or output.
// - Oscillator enable bit also drives clock out.
// - Serial clock independent of conversion clock.
module dcp_top (
	// Clock and reset
	input  wire logic                      mclk_i,
	input  wire logic                      rst_i,
	// Serial pins
	input  wire logic                      sclk_i,
	input  wire logic                      cs_n_i,
	input  wire logic                      edge_sel_i,
	input  wire logic                      din_i,
	output logic                           din_o,
	output logic                           din_oe_n_o,
	output logic                           dout_o,
	output logic                           dout_oe_n_o,
	// Conversion pins
	input  wire logic                      convert_i,
	output logic                           busy_o,
	input  wire logic                      osc_sel_i,
	input  wire logic                      conv_clk_i,
	output logic                           conv_clk_o,
	output logic                           conv_clk_oe_n_o,
	// General digital lines
	input  wire logic [dcp_pkg::GPIO_N-1:0] gpio_i,
	output logic [dcp_pkg::GPIO_N-1:0]     gpio_o,
	output logic [dcp_pkg::GPIO_N-1:0]     gpio_oe_n_o,
	// Core side: configuration
	input  wire logic                      two_wire_i,
	input  wire logic                      din_drive_i,
	input  wire logic                      oscillator_output_select_bit_i,
	input  wire logic [dcp_pkg::GPIO_N-1:0] gpio_dir_i,
	input  wire logic [dcp_pkg::GPIO_N-1:0] gpio_out_i,
	output logic [dcp_pkg::GPIO_N-1:0]     gpio_in_o,
	// Core side: serial data
	input  wire logic [dcp_pkg::SR_W-1:0]  tx_data_i,
	output logic                           tx_req_o,
	output logic [dcp_pkg::SR_W-1:0]       rx_data_o,
	output logic                           rx_valid_o,
	// Core side: conversion
	input  wire logic                      start_cmd_i,
	input  wire logic [dcp_pkg::RES_W-1:0] adc_result_i,
	output logic                           conv_start_o,
	output logic [dcp_pkg::RES_W-1:0]      result_o,
	output logic                           result_valid_o
);
	import dcp_pkg::*;

	// ------------------------------------------------------------
	// Terminal counts
	// ------------------------------------------------------------
	localparam logic [BITCNT_W-1:0]  LAST_BIT =
		BITCNT_W'(SR_W - 1);
	localparam logic [CONVCNT_W-1:0] LAST_CONV =
		CONVCNT_W'(CONV_CLK_CYC - 1);
	localparam logic [OSCCNT_W-1:0]  LAST_OSC =
		OSCCNT_W'(OSC_HALF_CYC - 1);

	// ------------------------------------------------------------
	// State and decoded strobes
	// ------------------------------------------------------------
	dcp_state_s cur_ff;
	dcp_state_s nxt_st;

	logic sclk_rise;
	logic sclk_fall;
	logic sclk_act;
	logic conv_trig;
	logic conversion_clock_edge;
	logic osc_on;

	// ------------------------------------------------------------
	// Edge detection on synchronised pins
	// ------------------------------------------------------------
	assign sclk_rise = cur_ff.sclk_s & ~cur_ff.sclk_p;
	assign sclk_fall = ~cur_ff.sclk_s & cur_ff.sclk_p;
	assign sclk_act  = (cur_ff.esel_s == EDGE_RISE) ?
		sclk_rise : sclk_fall;
	// Each serial clock phase must last at least one core
	// cycle; shorter phases can slip past the detector unseen.
	assign conv_trig = (cur_ff.conv_s & ~cur_ff.conv_p)
		| start_cmd_i;
	// Clock is sensed at the pin, driven or not, so every
	// device sharing the line sees the same delay.
	assign conversion_clock_edge = cur_ff.conversion_clock_s & ~cur_ff.conversion_clock_p;
	// Pin select or control bit, whichever is set
	assign osc_on    = cur_ff.osel_s | oscillator_output_select_bit_i;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic frame_start;
		frame_start = 1'b0;
		nxt_st = cur_ff;

		// --------------------------------------------------------
		// Pin synchronisers
		// --------------------------------------------------------
		// Two stages each; the second stage feeds logic, and edge-sensed pins also a third copy
		nxt_st.sclk_m = sclk_i;
		nxt_st.sclk_s = cur_ff.sclk_m;
		nxt_st.sclk_p = cur_ff.sclk_s;

		nxt_st.cs_m   = cs_n_i;
		nxt_st.cs_s   = cur_ff.cs_m;
		nxt_st.cs_p   = cur_ff.cs_s;

		nxt_st.esel_m = edge_sel_i;
		nxt_st.esel_s = cur_ff.esel_m;

		nxt_st.din_m  = din_i;
		nxt_st.din_s  = cur_ff.din_m;

		nxt_st.conv_m = convert_i;
		nxt_st.conv_s = cur_ff.conv_m;
		nxt_st.conv_p = cur_ff.conv_s;

		nxt_st.osel_m = osc_sel_i;
		nxt_st.osel_s = cur_ff.osel_m;

		nxt_st.conversion_clock_m = conv_clk_i;
		nxt_st.conversion_clock_s = cur_ff.conversion_clock_m;
		nxt_st.conversion_clock_p = cur_ff.conversion_clock_s;

		nxt_st.gin_m  = gpio_i;
		nxt_st.gin_s  = cur_ff.gin_m;

		// --------------------------------------------------------
		// Strobes last one cycle unless set below
		// --------------------------------------------------------
		nxt_st.rx_valid   = 1'b0;
		nxt_st.tx_req     = 1'b0;
		nxt_st.res_valid  = 1'b0;
		nxt_st.conv_start = 1'b0;

		// --------------------------------------------------------
		// Serial port, runs on sampled serial clock edges
		// --------------------------------------------------------
		// Frame opens one cycle after the synced select falls;
		// the first byte is on the pin long before the first
		// active edge that any legal host can make.
		frame_start = ~cur_ff.cs_s & cur_ff.cs_p;
		if (cur_ff.cs_s) begin
			// Idle: counter cleared so a cut byte is dropped
			nxt_st.bit_cnt = '0;
		end else if (sclk_act) begin
			nxt_st.rx_sr = {cur_ff.rx_sr[SR_W-2:0],
				cur_ff.din_s};
			nxt_st.bit_cnt = cur_ff.bit_cnt + 1'b1;
			if (cur_ff.bit_cnt == LAST_BIT) begin
				nxt_st.rx_data = {cur_ff.rx_sr[SR_W-2:0],
					cur_ff.din_s};
				nxt_st.rx_valid = 1'b1;
				frame_start = 1'b1;
			end else begin
				nxt_st.tx_sr = {cur_ff.tx_sr[SR_W-2:0],
					1'b0};
				nxt_st.sdo = cur_ff.tx_sr[SR_W-2];
			end
		end
		// New byte taken at frame start and each byte boundary
		if (frame_start) begin
			nxt_st.tx_sr  = tx_data_i;
			nxt_st.sdo    = tx_data_i[SR_W-1];
			nxt_st.tx_req = 1'b1;
		end

		// --------------------------------------------------------
		// Data-in pin turnaround
		// --------------------------------------------------------
		// Driven only in two-wire reads. Built from the second
		// sync stage, so it follows data out by one cycle.
		nxt_st.din_oe_n = ~(~cur_ff.cs_s & two_wire_i
			& din_drive_i);

		// --------------------------------------------------------
		// Internal oscillator
		// --------------------------------------------------------
		if (osc_on) begin
			if (cur_ff.osc_cnt == LAST_OSC) begin
				nxt_st.osc_cnt = '0;
				nxt_st.osc_clk = ~cur_ff.osc_clk;
			end else begin
				nxt_st.osc_cnt = cur_ff.osc_cnt + 1'b1;
			end
		end else begin
			// Stopped low so restart begins with a full phase
			nxt_st.osc_cnt = '0;
			nxt_st.osc_clk = 1'b0;
		end
		nxt_st.osc_oe_n = ~osc_on;

		// --------------------------------------------------------
		// Conversion sequencer, independent of chip select
		// --------------------------------------------------------
		case (cur_ff.st)
			CONV_IDLE: begin
				// A trigger during a conversion is ignored
				if (conv_trig) begin
					nxt_st.st         = CONV_RUN;
					nxt_st.busy       = 1'b1;
					nxt_st.conv_cnt   = '0;
					nxt_st.conv_start = 1'b1;
				end
			end
			CONV_RUN: begin
				// Edges counted at the pin, whichever side drives
				if (conversion_clock_edge) begin
					if (cur_ff.conv_cnt == LAST_CONV) begin
						nxt_st.st        = CONV_IDLE;
						nxt_st.result    = adc_result_i;
						nxt_st.res_valid = 1'b1;
						nxt_st.busy      = 1'b0;
					end else begin
						nxt_st.conv_cnt =
							cur_ff.conv_cnt + 1'b1;
					end
				end
			end
			default: begin
				nxt_st.st   = CONV_IDLE;
				nxt_st.busy = 1'b0;
			end
		endcase

		// --------------------------------------------------------
		// General digital lines
		// --------------------------------------------------------
		nxt_st.gout  = gpio_out_i;
		nxt_st.goe_n = ~gpio_dir_i;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cur_ff <= RST_STATE;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// Serial pin outputs
	// ------------------------------------------------------------
	// Same path for both wire modes; data out floats only with select high
	assign dout_o      = cur_ff.sdo;
	assign dout_oe_n_o = cur_ff.cs_s;
	assign din_o       = cur_ff.sdo;
	assign din_oe_n_o  = cur_ff.din_oe_n;

	// ------------------------------------------------------------
	// Conversion pin outputs
	// ------------------------------------------------------------
	assign busy_o          = cur_ff.busy;
	assign conv_clk_o      = cur_ff.osc_clk;
	assign conv_clk_oe_n_o = cur_ff.osc_oe_n;

	// ------------------------------------------------------------
	// Core side outputs
	// ------------------------------------------------------------
	assign tx_req_o       = cur_ff.tx_req;
	assign rx_data_o      = cur_ff.rx_data;
	assign rx_valid_o     = cur_ff.rx_valid;
	assign conv_start_o   = cur_ff.conv_start;
	assign result_o       = cur_ff.result;
	assign result_valid_o = cur_ff.res_valid;

	// ------------------------------------------------------------
	// General digital line outputs
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < GPIO_N; gi++) begin : g_line
			assign gpio_o[gi]      = cur_ff.gout[gi];
			assign gpio_oe_n_o[gi] = cur_ff.goe_n[gi];
			assign gpio_in_o[gi]   = cur_ff.gin_s[gi];
		end
	endgenerate

endmodule

//--- testbench/dcp_props.sv
// Checker for dcp_top, watching its ports only.
// Assumes one clock domain with an active-high reset.
`timescale 1ns/1ps
module dcp_props (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic start_cmd_i,
	input wire logic osc_sel_i,
	input wire logic oscillator_output_select_bit_i,
	input wire logic two_wire_i,
	input wire logic din_o,
	input wire logic din_oe_n_o,
	input wire logic dout_o,
	input wire logic dout_oe_n_o,
	input wire logic busy_o,
	input wire logic conv_start_o,
	input wire logic result_valid_o,
	input wire logic conv_clk_o,
	input wire logic conv_clk_oe_n_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Pins pass two sync flops and, except for the data-out enable, a register
	sequence s_cs_hi; cs_n_i[*4]; endsequence
	sequence s_cs_lo; !cs_n_i[*4]; endsequence
	sequence s_osc_off; (!osc_sel_i && !oscillator_output_select_bit_i)[*4]; endsequence
	a_busy_start: assert property (conv_start_o |-> busy_o)
		else $error("busy low at conversion start");
	a_busy_end: assert property ($fell(busy_o) |-> result_valid_o)
		else $error("busy fell without a result");
	a_trig_idle: assert property (
		start_cmd_i && !busy_o |=> conv_start_o)
		else $error("idle trigger did not start");
	a_no_retrig: assert property (busy_o |=> !conv_start_o)
		else $error("conversion restarted while busy");
	a_sel_float: assert property (
		s_cs_hi |-> dout_oe_n_o && din_oe_n_o)
		else $error("data pins driven while deselected");
	a_sel_drive: assert property (s_cs_lo |-> !dout_oe_n_o)
		else $error("data out floats while selected");
	a_din_mirror: assert property (
		!din_oe_n_o && !cs_n_i |-> two_wire_i && din_o == dout_o)
		else $error("data-in drive differs from data out");
	a_osc_off: assert property (
		s_osc_off |-> conv_clk_oe_n_o && !conv_clk_o)
		else $error("conversion clock driven while off");
	a_osc_bit: assert property (
		oscillator_output_select_bit_i[*2] |-> !conv_clk_oe_n_o)
		else $error("enable bit did not drive the clock pin");
endmodule

bind dcp_top dcp_props dcp_props_inst (.mclk_i, .rst_i, .cs_n_i,
	.start_cmd_i, .osc_sel_i, .oscillator_output_select_bit_i, .two_wire_i,
	.din_o, .din_oe_n_o,
	.dout_o, .dout_oe_n_o, .busy_o, .conv_start_o, .result_valid_o,
	.conv_clk_o, .conv_clk_oe_n_o);

//--- testbench/dcp_host.sv
// Host model: drives select, serial clock and data into dcp_top.
// Assumes the bench resolves the two-way data pin.
`timescale 1ns/1ps
module dcp_host (
	input  wire logic edge_sel_i,
	input  wire logic miso_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o
);
	initial begin
		sclk_o = 1'h0;
		cs_n_o = 1'h1;
		mosi_o = 1'h0;
	end
	// One byte per frame, MSB first; clock still between frames
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		sclk_o = ~edge_sel_i;
		#113 cs_n_o = 1'h0;
		#300;
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			#100 rx[i] = miso_i;
			sclk_o = edge_sel_i;
			#100 sclk_o = ~edge_sel_i;
		end
		#100 cs_n_o = 1'h1;
		// Released line shows the inverse, never a stale bit
		mosi_o = ~mosi_o;
	endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for dcp_top with the host model on the pins.
// Assumes dcp_props is bound from its own file.
`timescale 1ns/1ps
module tb;
	import dcp_pkg::*;
	logic              mclk_i = 1'h0, rst_i = 1'h1, edge_sel_i = 1'h0;
	logic              convert_i = 1'h0, osc_sel_i = 1'h0, ext_clk = 1'h0;
	logic              two_wire_i = 1'h0, din_drive_i = 1'h0;
	logic              oscillator_output_select_bit_i = 1'h0, start_cmd_i = 1'h0;
	logic [GPIO_N-1:0] gpio_i = 4'h9, gpio_dir_i = 4'h5, gpio_out_i = 4'h3;
	logic [SR_W-1:0]   tx_data_i = 8'hA5;
	logic [RES_W-1:0]  adc_result_i = 12'h000;
	logic              sclk_i, cs_n_i, mosi, din_i, din_o, din_oe_n_o;
	logic              dout_o, dout_oe_n_o, busy_o, conv_clk_i, conv_clk_o;
	logic              conv_clk_oe_n_o, tx_req_o, rx_valid_o, conv_start_o;
	logic              result_valid_o;
	logic [GPIO_N-1:0] gpio_o, gpio_oe_n_o, gpio_in_o;
	logic [SR_W-1:0]   rx_data_o;
	logic [RES_W-1:0]  result_o;
	int                failures = 0;
	int                comparisons = 0;
	int                rx_pulses = 0;
	int                tx_pulses = 0;
	// Pulses counted at the edge, before the design updates
	always @(posedge mclk_i) begin
		rx_pulses += rx_valid_o;
		tx_pulses += tx_req_o;
	end
	// Two-way pins: the device wins while its enable is low
	assign din_i = din_oe_n_o ? mosi : din_o;
	assign conv_clk_i = conv_clk_oe_n_o ? ext_clk : conv_clk_o;
	always #12.5 mclk_i = ~mclk_i;
	always #200 ext_clk = ~ext_clk;
	dcp_top dcp_top_inst (.mclk_i, .rst_i, .sclk_i, .cs_n_i, .edge_sel_i,
		.din_i, .din_o, .din_oe_n_o, .dout_o, .dout_oe_n_o, .convert_i,
		.busy_o, .osc_sel_i, .conv_clk_i, .conv_clk_o, .conv_clk_oe_n_o,
		.gpio_i, .gpio_o, .gpio_oe_n_o, .two_wire_i, .din_drive_i,
		.oscillator_output_select_bit_i, .gpio_dir_i, .gpio_out_i, .gpio_in_o,
		.tx_data_i, .tx_req_o, .rx_data_o, .rx_valid_o, .start_cmd_i,
		.adc_result_i, .conv_start_o, .result_o, .result_valid_o);
	dcp_host dcp_host_inst (.edge_sel_i, .miso_i(dout_o), .sclk_o(sclk_i),
		.cs_n_o(cs_n_i), .mosi_o(mosi));
	task automatic chk(input string nm, input logic [11:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic t_serial(input logic es, input logic tw);
		logic [7:0] hs, got, txb;
		int         rx0, tx0;
		hs = 8'h3C ^ {6'h00, tw, es};
		txb = ~hs;
		@(posedge mclk_i);
		edge_sel_i <= es;
		two_wire_i <= tw;
		din_drive_i <= tw;
		tx_data_i <= txb;
		tick(4);
		rx0 = rx_pulses;
		tx0 = tx_pulses;
		fork
			dcp_host_inst.xfer(hs, got);
			#800 chk("din oe", 12'(din_oe_n_o), 12'(!tw));
		join
		tick(6);
		chk("dout", 12'(got), 12'(txb));
		chk("rx pulses", 12'(rx_pulses - rx0), 12'h001);
		chk("tx pulses", 12'(tx_pulses - tx0), 12'h002);
		if (!tw)
			chk("rx", 12'(rx_data_o), 12'(hs));
		chk("dout oe", 12'(dout_oe_n_o), 12'h001);
	endtask
	task automatic t_conv(input logic ext);
		int n;
		@(posedge mclk_i);
		osc_sel_i <= !ext;
		adc_result_i <= ext ? 12'h5A3 : 12'hC3F;
		tick(5);
		chk("conversion_clock oe", 12'(conv_clk_oe_n_o), 12'(ext));
		@(posedge mclk_i);
		if (ext)
			start_cmd_i <= 1'h1;
		else
			convert_i <= 1'h1;
		n = 0;
		do begin
			@(posedge mclk_i);
			start_cmd_i <= 1'h0;
			#1 n++;
		end while (conv_start_o !== 1'h1 && n < 12);
		chk("start", 12'(conv_start_o), 12'h001);
		chk("busy", 12'(busy_o), 12'h001);
		n = 0;
		// A trigger mid-conversion must be dropped
		do begin
			@(posedge mclk_i);
			start_cmd_i <= (n == 20);
			#1 n++;
		end while (result_valid_o !== 1'h1 && n < 400);
		chk("result", result_o, adc_result_i);
		chk("span", 12'(n >= 176 && n <= 200), 12'h001);
		@(posedge mclk_i);
		convert_i <= 1'h0;
		tick(10);
		chk("idle", 12'(busy_o), 12'h000);
	endtask
	task automatic t_misc;
		chk("gpio oe", 12'(gpio_oe_n_o), 12'h00A);
		chk("gpio out", 12'(gpio_o), 12'h003);
		chk("gpio in", 12'(gpio_in_o), 12'h009);
		@(posedge mclk_i);
		oscillator_output_select_bit_i <= 1'h1;
		tick(4);
		chk("osc bit", 12'(conv_clk_oe_n_o), 12'h000);
		@(posedge mclk_i);
		rst_i <= 1'h1;
		tick(2);
		chk("clear", result_o | 12'(rx_data_o), 12'h000);
		@(posedge mclk_i);
		rst_i <= 1'h0;
	endtask
	task automatic test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'h0;
		tick(4);
		for (int i = 0; i < 4; i++)
			t_serial(i[0], i[1]);
		t_conv(1'h0);
		t_conv(1'h1);
		t_misc;
		test_done;
	end
	initial begin
		#100000;
		failures++;
		test_done;
	end
endmodule
